// ===== hdl/dcr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the drive command bank.
// Assumes: Word addresses as seen by the polling master; one 16-bit word per address.
// Notes: Definitions only.
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH
`define DCR_ADDR_FREQ 16'h0380
`define DCR_ADDR_SPEED 16'h0381
`define DCR_ADDR_RUN 16'h0382
`define DCR_ADDR_ACCEL 16'h0383
`define DCR_ADDR_DECEL 16'h0384
`define DCR_ADDR_LOOP_REF 16'h0388
`define DCR_ADDR_LOOP_FB 16'h0389
`define DCR_ADDR_RESTORE 16'h03e2
`define DCR_ADDR_HIST_CLR 16'h03e5
`define DCR_RUN_BIT 0
`define DCR_DIR_BIT 1
`define DCR_COAST_BIT 3
`define DCR_RUN_MASK 16'h000b
`define DCR_WORD_RESET 16'h0000
`define DCR_REF_SRC_COMM 4'h4
`define DCR_FB_SRC_COMM 4'h2
`define DCR_RESTORE_MAX 16'h0005
`define DCR_HIST_CLR_YES 16'h0001
`define DCR_OV_LIMIT_V 10'h190
`define DCR_UV_LIMIT_V 10'h0b4
`define DCR_RATED_PCT 9'h064
`define DCR_OL_PCT 9'h096
`define DCR_CLK_HZ 20000000
`define DCR_OL_TIME_S 60
`endif

// ===== hdl/dcr_pkg.sv
// Purpose: Types shared by the drive command bank.
// Assumes: Register port driven by a frame decoder on the same clock.
// Notes: Constants live in dcr_regs.svh.
package dcr_pkg;
   // One register request from the frame decoder.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dcr_req_t;
   // Latched protective trips.
   typedef struct packed {
      logic ov;
      logic uv;
      logic ol;
      logic phase;
      logic oc;
   } dcr_trip_t;
endpackage : dcr_pkg

// ===== hdl/dcr_bank.sv
// Purpose: Command and memory-control register bank of a motor drive, with protective trips.
// Assumes: Requests and sensor words come from logic on clk; sensors give volts and percent of rated current.
// Notes: Every output is registered; write answers come one cycle after the request.
`timescale 1ns/1ns
`default_nettype none
`include "dcr_regs.svh"

// Summary of operation
// - Frequency and speed words are writable only with communication frequency source.
// - Run word bit 0 is stop/run, bit 1 is reverse/forward.
// - Coast stop fires on a 0 to 1 write of bit 3 only.
// - Run word writes are ignored unless the run source is communication.
// - Loop reference word is writable only when its source select equals 4.
// - Loop feedback word is writable only when its source select equals 2.
// - Restore word code 0 to 5 selects which defaults to restore.
// - Restore requests are rejected while any trip is active.
// - Writing 1 to history clear erases fault history; 0 does nothing.
// - Bus voltage above 400 V trips overvoltage and cuts the output.
// - Bus voltage below 180 V trips undervoltage and cuts the output.
// - Current at 150 percent for longer than one minute trips overload.
// - An open output phase trips phase loss and cuts the output.
// - Current above rated trips overcurrent and cuts the output.
// - A latched fault cannot be cleared while its cause persists.
module dcr_bank #(
   parameter int unsigned OL_CYCLES = `DCR_OL_TIME_S * `DCR_CLK_HZ
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port from the frame decoder.
   input wire dcr_pkg::dcr_req_t req,
   output logic [15:0] rdata,
   output logic rd_valid,
   output logic wr_done,
   output logic wr_refused,
   // Source selects.
   input wire logic freq_source_is_comm,
   input wire logic run_source_is_comm,
   input wire logic [3:0] loop_reference_source_select,
   input wire logic [3:0] loop_feedback_source_select,
   // Sensing and fault clear.
   input wire logic [9:0] dc_bus_volts,
   input wire logic [8:0] output_current_pct,
   input wire logic [2:0] phase_open,
   input wire logic fault_clear_req,
   // Held command words.
   output logic [15:0] frequency_setpoint,
   output logic [15:0] speed_setpoint,
   output logic [15:0] run_control,
   output logic [15:0] accel_ramp_time,
   output logic [15:0] decel_ramp_time,
   output logic [15:0] loop_reference_value,
   output logic [15:0] loop_feedback_value,
   output logic [15:0] parameter_default_restore,
   // Drive actions.
   output logic drive_enable,
   output logic coast_stop,
   output logic restore_pulse,
   output logic history_clear,
   output dcr_pkg::dcr_trip_t trips
);

   // Condition levels seen this cycle.
   logic cond_ov;
   logic cond_uv;
   logic cond_oc;
   logic cond_phase;
   logic cond_ol;
   logic ol_high;
   logic [31:0] ol_count;
   logic [31:0] next_ol_count;
   dcr_pkg::dcr_trip_t cond;
   dcr_pkg::dcr_trip_t next_trips;
   logic next_drive_enable;

   // Register group next values.
   logic [15:0] next_frequency_setpoint;
   logic [15:0] next_speed_setpoint;
   logic [15:0] next_run_control;
   logic [15:0] next_accel_ramp_time;
   logic [15:0] next_decel_ramp_time;
   logic [15:0] next_loop_reference_value;
   logic [15:0] next_loop_feedback_value;
   logic [15:0] next_parameter_default_restore;
   logic [15:0] next_rdata;
   logic next_rd_valid;
   logic next_wr_done;
   logic next_wr_refused;
   logic next_coast_stop;
   logic next_restore_pulse;
   logic next_history_clear;
   logic trip_any;

   // Protective comparisons on the sensed values.
   assign cond_ov = dc_bus_volts > `DCR_OV_LIMIT_V;
   assign cond_uv = dc_bus_volts < `DCR_UV_LIMIT_V;
   assign cond_oc = output_current_pct > `DCR_RATED_PCT;
   assign cond_phase = |phase_open;
   assign ol_high = output_current_pct >= `DCR_OL_PCT;
   assign cond_ol = ol_high && (ol_count >= OL_CYCLES);
   assign trip_any = |trips;

   // Overload timer, trip and output enable next values.
   always_comb
   begin
      cond = '{ov: cond_ov, uv: cond_uv, ol: cond_ol, phase: cond_phase, oc: cond_oc};
      next_ol_count = ol_count;
      if (!ol_high)
      begin
         next_ol_count = 32'h0000_0000;
      end
      else if (ol_count < OL_CYCLES)
      begin
         next_ol_count = ol_count + 32'h0000_0001;
      end
      // A trip bit clears only once its own cause is gone; a present cause always wins.
      next_trips = trips | cond;
      if (fault_clear_req)
      begin
         next_trips = cond;
      end
      next_drive_enable = next_run_control[`DCR_RUN_BIT] && !(|next_trips) && !(|cond);
   end

   // Protection registers.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ol_count <= 32'h0000_0000;
         trips <= '0;
         drive_enable <= 1'b0;
      end
      else
      begin
         ol_count <= next_ol_count;
         trips <= next_trips;
         drive_enable <= next_drive_enable;
      end
   end

   // Write gating, read mux and one-cycle action pulses.
   always_comb
   begin
      next_frequency_setpoint = frequency_setpoint;
      next_speed_setpoint = speed_setpoint;
      next_run_control = run_control;
      next_accel_ramp_time = accel_ramp_time;
      next_decel_ramp_time = decel_ramp_time;
      next_loop_reference_value = loop_reference_value;
      next_loop_feedback_value = loop_feedback_value;
      next_parameter_default_restore = parameter_default_restore;
      next_rd_valid = req.rd && !req.wr;
      next_wr_done = req.wr;
      next_wr_refused = 1'b0;
      next_coast_stop = 1'b0;
      next_restore_pulse = 1'b0;
      next_history_clear = 1'b0;
      next_rdata = 16'h0000;
      if (req.wr)
      begin
         case (req.addr)
            `DCR_ADDR_FREQ:
            begin
               if (freq_source_is_comm) next_frequency_setpoint = req.wdata;
               else next_wr_refused = 1'b1;
            end
            `DCR_ADDR_SPEED:
            begin
               if (freq_source_is_comm) next_speed_setpoint = req.wdata;
               else next_wr_refused = 1'b1;
            end
            `DCR_ADDR_RUN:
            begin
               if (run_source_is_comm)
               begin
                  next_run_control = req.wdata & `DCR_RUN_MASK;
                  next_coast_stop = req.wdata[`DCR_COAST_BIT] && !run_control[`DCR_COAST_BIT];
               end
               else next_wr_refused = 1'b1;
            end
            `DCR_ADDR_ACCEL: next_accel_ramp_time = req.wdata;
            `DCR_ADDR_DECEL: next_decel_ramp_time = req.wdata;
            `DCR_ADDR_LOOP_REF:
            begin
               if (loop_reference_source_select == `DCR_REF_SRC_COMM) next_loop_reference_value = req.wdata;
               else next_wr_refused = 1'b1;
            end
            `DCR_ADDR_LOOP_FB:
            begin
               if (loop_feedback_source_select == `DCR_FB_SRC_COMM) next_loop_feedback_value = req.wdata;
               else next_wr_refused = 1'b1;
            end
            `DCR_ADDR_RESTORE:
            begin
               // Codes above the input/output group are not defined and are refused.
               if (trip_any || req.wdata > `DCR_RESTORE_MAX)
               begin
                  next_wr_refused = 1'b1;
               end
               else
               begin
                  next_parameter_default_restore = req.wdata;
                  next_restore_pulse = req.wdata != `DCR_WORD_RESET;
               end
            end
            `DCR_ADDR_HIST_CLR: next_history_clear = req.wdata == `DCR_HIST_CLR_YES;
            default: next_wr_refused = 1'b1;
         endcase
      end
      else if (req.rd)
      begin
         case (req.addr)
            `DCR_ADDR_FREQ: next_rdata = frequency_setpoint;
            `DCR_ADDR_SPEED: next_rdata = speed_setpoint;
            `DCR_ADDR_RUN: next_rdata = run_control & `DCR_RUN_MASK;
            `DCR_ADDR_ACCEL: next_rdata = accel_ramp_time;
            `DCR_ADDR_DECEL: next_rdata = decel_ramp_time;
            `DCR_ADDR_LOOP_REF: next_rdata = loop_reference_value;
            `DCR_ADDR_LOOP_FB: next_rdata = loop_feedback_value;
            `DCR_ADDR_RESTORE: next_rdata = parameter_default_restore;
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // Register bank flops.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         frequency_setpoint <= `DCR_WORD_RESET;
         speed_setpoint <= `DCR_WORD_RESET;
         run_control <= `DCR_WORD_RESET;
         accel_ramp_time <= `DCR_WORD_RESET;
         decel_ramp_time <= `DCR_WORD_RESET;
         loop_reference_value <= `DCR_WORD_RESET;
         loop_feedback_value <= `DCR_WORD_RESET;
         parameter_default_restore <= `DCR_WORD_RESET;
         rdata <= 16'h0000;
         rd_valid <= 1'b0;
         wr_done <= 1'b0;
         wr_refused <= 1'b0;
         coast_stop <= 1'b0;
         restore_pulse <= 1'b0;
         history_clear <= 1'b0;
      end
      else
      begin
         frequency_setpoint <= next_frequency_setpoint;
         speed_setpoint <= next_speed_setpoint;
         run_control <= next_run_control;
         accel_ramp_time <= next_accel_ramp_time;
         decel_ramp_time <= next_decel_ramp_time;
         loop_reference_value <= next_loop_reference_value;
         loop_feedback_value <= next_loop_feedback_value;
         parameter_default_restore <= next_parameter_default_restore;
         rdata <= next_rdata;
         rd_valid <= next_rd_valid;
         wr_done <= next_wr_done;
         wr_refused <= next_wr_refused;
         coast_stop <= next_coast_stop;
         restore_pulse <= next_restore_pulse;
         history_clear <= next_history_clear;
      end
   end

   // Checks on the bank and the protection.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_freq_blocked;
      req.wr && !freq_source_is_comm && (req.addr == `DCR_ADDR_FREQ || req.addr == `DCR_ADDR_SPEED);
   endsequence
   sequence s_coast_rise;
      req.wr && run_source_is_comm && req.addr == `DCR_ADDR_RUN && req.wdata[`DCR_COAST_BIT]
         && !run_control[`DCR_COAST_BIT];
   endsequence
   sequence s_coast_held;
      req.wr && req.addr == `DCR_ADDR_RUN && run_control[`DCR_COAST_BIT];
   endsequence
   sequence s_run_read;
      req.rd && !req.wr && req.addr == `DCR_ADDR_RUN;
   endsequence

   a_freq_gate: assert property (s_freq_blocked |=> $stable(frequency_setpoint) && $stable(speed_setpoint)
      && wr_refused) else $error("Frequency word changed without communication source.");
   a_run_bits: assert property (drive_enable |-> run_control[`DCR_RUN_BIT])
      else $error("Output enabled with run bit clear.");
   a_coast_edge: assert property (s_coast_rise |=> coast_stop)
      else $error("Coast stop missed on rising bit.");
   a_coast_level: assert property (s_coast_held |=> !coast_stop)
      else $error("Coast stop retriggered by held level.");
   a_run_gate: assert property (req.wr && !run_source_is_comm && req.addr == `DCR_ADDR_RUN
      |=> $stable(run_control) && !coast_stop) else $error("Run word written without communication source.");
   a_ref_gate: assert property (req.wr && req.addr == `DCR_ADDR_LOOP_REF
      && loop_reference_source_select != `DCR_REF_SRC_COMM |=> $stable(loop_reference_value))
      else $error("Loop reference written with wrong source.");
   a_fb_gate: assert property (req.wr && req.addr == `DCR_ADDR_LOOP_FB
      && loop_feedback_source_select != `DCR_FB_SRC_COMM |=> $stable(loop_feedback_value))
      else $error("Loop feedback written with wrong source.");
   a_restore_code: assert property (restore_pulse |-> parameter_default_restore inside {[16'h0001:16'h0005]})
      else $error("Restore pulse with an undefined code.");
   a_restore_trip: assert property (req.wr && req.addr == `DCR_ADDR_RESTORE && trip_any
      |=> !restore_pulse && wr_refused && $stable(parameter_default_restore))
      else $error("Restore taken during a trip.");
   a_hist_clear: assert property (req.wr && req.addr == `DCR_ADDR_HIST_CLR
      |=> history_clear == ($past(req.wdata) == `DCR_HIST_CLR_YES))
      else $error("History clear does not follow written value.");
   a_hist_idle: assert property (!(req.wr && req.addr == `DCR_ADDR_HIST_CLR) |=> !history_clear)
      else $error("History clear pulsed without a write.");
   a_ov_trip: assert property (cond_ov |=> trips.ov && !drive_enable)
      else $error("Overvoltage did not trip.");
   a_uv_trip: assert property (cond_uv |=> trips.uv && !drive_enable)
      else $error("Undervoltage did not trip.");
   a_ol_trip: assert property (ol_high && ol_count >= OL_CYCLES |=> trips.ol && !drive_enable)
      else $error("Overload time passed without trip.");
   a_ol_early: assert property (!ol_high |=> ol_count == 32'h0000_0000)
      else $error("Overload timer kept counting at normal current.");
   a_phase_trip: assert property (cond_phase |=> trips.phase && !drive_enable)
      else $error("Phase loss did not trip.");
   a_oc_trip: assert property (cond_oc |=> trips.oc && !drive_enable)
      else $error("Overcurrent did not trip.");
   a_trip_cut: assert property (trip_any |-> !drive_enable)
      else $error("Output enabled while a trip is latched.");
   a_fault_hold: assert property (fault_clear_req && cond_ov |=> trips.ov)
      else $error("Fault cleared while its cause persisted.");
   a_reserved_zero: assert property (run_control[15:4] == 12'h000 && !run_control[2])
      else $error("Reserved run word bits are set.");
   a_run_read: assert property (s_run_read |=> rd_valid && rdata[15:4] == 12'h000 && !rdata[2])
      else $error("Reserved run word bits read back as set.");
   a_write_answer: assert property (req.wr |=> wr_done && !rd_valid)
      else $error("Write not answered in the next cycle.");
   a_refuse_hold: assert property (wr_refused |-> $stable(frequency_setpoint) && $stable(speed_setpoint)
      && $stable(run_control) && $stable(loop_reference_value) && $stable(loop_feedback_value)
      && $stable(parameter_default_restore) && !restore_pulse && !coast_stop)
      else $error("Refused write changed a register.");

endmodule : dcr_bank
`default_nettype wire

// ===== testbench/dcr_master.sv
// Purpose: Polling master model that issues single register requests to the command bank.
// Assumes: One request per call; the answer is registered on the taking edge and sampled 1 ns after it.
// Notes: Released address and data show the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none
module dcr_master (
   // Clock.
   input wire logic clk,
   // Request and answer.
   output var dcr_pkg::dcr_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rd_valid,
   input wire logic wr_done,
   input wire logic wr_refused
);
   initial req = '0;
   // Raise a one-cycle request, release it, then sample the answer once it has settled.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
      output logic r);
      @(posedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
      q = rd_valid ? rdata : 16'hxxxx;  // A missing answer can never match.
      r = wr_done ? wr_refused : 1'bx;
   endtask : xfer
endmodule : dcr_master
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the drive command bank.
// Assumes: Overload time shortened to 20 cycles.
// Notes: Random traffic comes from a fixed-seed shift register.
`timescale 1ns/1ns
`default_nettype none
`include "dcr_regs.svh"
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fsrc = 1'b0;
   logic rsrc = 1'b0;
   logic [3:0] rsel = 4'h0;
   logic [3:0] fsel = 4'h0;
   logic [9:0] volts = 10'h12c;
   logic [8:0] pct = 9'h000;
   logic [2:0] ph = 3'h0;
   logic fclr = 1'b0;
   dcr_pkg::dcr_req_t req;
   dcr_pkg::dcr_trip_t trips;
   logic [15:0] rdata, q, rnd = 16'h345b;
   logic rd_valid, wr_done, wr_refused, drive_enable, coast_stop, restore_pulse, history_clear, r;
   logic [15:0] mdl [0:6] = '{default: 16'h0000};
   logic [15:0] adr [0:6] = '{`DCR_ADDR_FREQ, `DCR_ADDR_SPEED, `DCR_ADDR_RUN, `DCR_ADDR_LOOP_REF,
      `DCR_ADDR_LOOP_FB, `DCR_ADDR_ACCEL, `DCR_ADDR_DECEL};
   logic [15:0] held [0:6];
   logic [15:0] restore_word;
   int i;
   int bad_count = 0;
   int cmp_count = 0;
   // Clock at 20 MHz.
   always #25 clk = ~clk;
   // Design and polling master.
   dcr_bank #(.OL_CYCLES(20)) dcr_bank_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
      .rd_valid(rd_valid), .wr_done(wr_done), .wr_refused(wr_refused), .freq_source_is_comm(fsrc),
      .run_source_is_comm(rsrc), .loop_reference_source_select(rsel), .loop_feedback_source_select(fsel),
      .dc_bus_volts(volts), .output_current_pct(pct), .phase_open(ph), .fault_clear_req(fclr),
      .frequency_setpoint(held[0]), .speed_setpoint(held[1]), .run_control(held[2]), .accel_ramp_time(held[5]),
      .decel_ramp_time(held[6]), .loop_reference_value(held[3]), .loop_feedback_value(held[4]),
      .parameter_default_restore(restore_word),
      .drive_enable(drive_enable), .coast_stop(coast_stop), .restore_pulse(restore_pulse),
      .history_clear(history_clear), .trips(trips));
   dcr_master dcr_master_inst (.clk(clk), .req(req), .rdata(rdata), .rd_valid(rd_valid),
      .wr_done(wr_done), .wr_refused(wr_refused));
   // Next value of the stimulus shift register.
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   // Whether a word at table slot k may be written under the present source selects.
   function automatic logic ok(input int k);
      case (k)
         0, 1: ok = fsrc;
         2: ok = rsrc;
         3: ok = (rsel === `DCR_REF_SRC_COMM);
         4: ok = (fsel === `DCR_FB_SRC_COMM);
         default: ok = 1'b1;
      endcase
   endfunction : ok
   // Compare and count.
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Print the counts and the verdict, then stop.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // One trip case: apply a cause, check trip and output, try a restore, try to clear, remove it, clear.
   task automatic trip_case(input logic [9:0] v, input logic [8:0] p, input logic [2:0] o, input logic [4:0] e,
      input int w);
      @(posedge clk);
      volts <= v;
      pct <= p;
      ph <= o;
      repeat (w + 2) @(posedge clk);
      #1;
      chk("trips", {11'h0, e}, {11'h0, trips});
      chk("drive", {15'h0, e == 5'h0}, {15'h0, drive_enable});
      dcr_master_inst.xfer(1'b1, `DCR_ADDR_RESTORE, 16'h0001, q, r);
      chk("restore refused", {15'h0, e != 5'h0}, {15'h0, r});
      chk("restore pulse", {15'h0, e == 5'h0}, {15'h0, restore_pulse});
      @(posedge clk);
      fclr <= 1'b1;
      @(posedge clk);
      fclr <= 1'b0;
      @(posedge clk);
      #1;
      chk("held trips", {11'h0, e}, {11'h0, trips});
      @(posedge clk);
      volts <= 10'h12c;
      pct <= 9'h000;
      ph <= 3'h0;
      @(posedge clk);
      fclr <= 1'b1;
      @(posedge clk);
      fclr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("cleared", 16'h0000, {11'h0, trips});
      chk("drive back", 16'h0001, {15'h0, drive_enable});
   endtask : trip_case
   // Watchdog.
   initial
   begin
      #(50 * 20000);
      bad_count++;
      finish_test();
   end
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 60; k++)
      begin
         rnd = nxt(rnd);
         i = rnd % 7;
         @(posedge clk);
         fsrc <= rnd[3];
         rsrc <= rnd[4];
         rsel <= rnd[5] ? 4'h4 : rnd[9:6];
         fsel <= rnd[10] ? 4'h2 : rnd[14:11];
         rnd = nxt(rnd);
         dcr_master_inst.xfer(1'b1, adr[i], rnd, q, r);
         chk("refused", {15'h0, !ok(i)}, {15'h0, r});
         if (ok(i))
            mdl[i] = (i == 2) ? (rnd & `DCR_RUN_MASK) : rnd;
         dcr_master_inst.xfer(1'b0, adr[i], 16'h0000, q, r);
         chk("word", mdl[i], q);
         chk("held", mdl[i], held[i]);
      end
      dcr_master_inst.xfer(1'b1, 16'h0385, 16'h1234, q, r);
      chk("unmapped wr", 16'h0001, {15'h0, r});
      dcr_master_inst.xfer(1'b0, 16'h0385, 16'h0000, q, r);
      chk("unmapped rd", 16'h0000, q);
      @(posedge clk);
      rsrc <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         dcr_master_inst.xfer(1'b1, `DCR_ADDR_RUN, (k == 1 || k == 2 || k == 4) ? 16'h0008 : 16'h0000, q, r);
         chk("coast", {15'h0, k == 1 || k == 4}, {15'h0, coast_stop});
      end
      dcr_master_inst.xfer(1'b1, `DCR_ADDR_RUN, 16'hfff3, q, r);
      dcr_master_inst.xfer(1'b0, `DCR_ADDR_RUN, 16'h0000, q, r);
      chk("run word", 16'h0003, q);
      for (int c = 0; c < 7; c++)
      begin
         dcr_master_inst.xfer(1'b1, `DCR_ADDR_RESTORE, c[15:0], q, r);
         chk("code refused", {15'h0, c > 5}, {15'h0, r});
         chk("code pulse", {15'h0, c > 0 && c < 6}, {15'h0, restore_pulse});
         chk("code word", (c > 5) ? 16'h0005 : c[15:0], restore_word);
      end
      for (int c = 0; c < 2; c++)
      begin
         dcr_master_inst.xfer(1'b1, `DCR_ADDR_HIST_CLR, c[15:0], q, r);
         chk("history", c[15:0], {15'h0, history_clear});
      end
      trip_case(10'h191, 9'h000, 3'h0, 5'h10, 0);
      trip_case(10'h190, 9'h000, 3'h0, 5'h00, 0);
      trip_case(10'h0b3, 9'h000, 3'h0, 5'h08, 0);
      trip_case(10'h0b4, 9'h000, 3'h0, 5'h00, 0);
      trip_case(10'h12c, 9'h065, 3'h0, 5'h01, 0);
      trip_case(10'h12c, 9'h064, 3'h0, 5'h00, 0);
      trip_case(10'h12c, 9'h000, 3'h2, 5'h02, 0);
      trip_case(10'h12c, 9'h096, 3'h0, 5'h01, 0);
      trip_case(10'h12c, 9'h096, 3'h0, 5'h05, 25);
      finish_test();
   end
endmodule : tb
`default_nettype wire
